// ===== plpc_pkg.sv
// shared constants and types for the low-power width-reduction control
`default_nettype none
package plpc_pkg;
  localparam int CLK_NS = 20;
  localparam int ENTRY_HOLD_NS = 100;
  localparam int EXIT_HOLD_NS = 500;
  localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXIT_HOLD_CYC = (EXIT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] LP_TX_NEED = 3'h4;
  localparam logic [1:0] LP_RX_NEED = 2'h2;
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [3:0] CODE_DOWN = 4'h0;
  localparam logic [3:0] CODE_UP = 4'h1;
  localparam logic [3:0] CODE_RETRAIN = 4'h2;
  localparam logic [3:0] CODE_STBY = 4'h7;
  localparam logic [3:0] CODE_SLEEP = 4'h8;
  localparam logic [3:0] CODE_UP_LP1 = 4'hB;
  localparam int CMD_STBY = 0;
  localparam int CMD_SLEEP = 1;
  localparam int CMD_WR_ENTER = 2;
  localparam int CMD_WR_EXIT = 3;
  localparam int CMD_WAKE = 4;
  localparam int CMD_DOWN = 5;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_PREV_LSB = 4;
  localparam int ST_LANE_LSB = 8;
  localparam int ST_FEC_LSB = 16;
  localparam logic [2:0] FEC_NONE = 3'h0;
  localparam logic [1:0] ARC_ONE = 2'h1;
  localparam logic [1:0] ARC_TWO = 2'h2;
  localparam logic [15:0] CC_INTERVAL_RST = 16'h1000;
  localparam logic [3:0] CC_COUNT_RST = 4'h2;
  typedef enum logic [1:0] {
    SEQ_DATA = 2'h0, SEQ_CC = 2'h1, SEQ_LP_RED = 2'h2, SEQ_LP_FULL = 2'h3
  } plpc_seq_t;
  typedef enum logic [10:0] {
    ST_DOWN = 11'h001, ST_UP = 11'h002, ST_STBY = 11'h004,
    ST_SLEEP = 11'h008, ST_WREQ = 11'h010, ST_WHOLD = 11'h020,
    ST_WTRAIN = 11'h040, ST_WRED = 11'h080, ST_XREQ = 11'h100,
    ST_XHOLD = 11'h200, ST_XTRAIN = 11'h400
  } plpc_state_t;
  typedef struct packed {
    logic [15:0] cc_interval;
    logic [7:0] rsvd1;
    logic [3:0] cc_count;
    logic [2:0] rsvd0;
    logic cc_en;
  } plpc_ctrl_t;
  localparam plpc_ctrl_t CTRL_RST = '{cc_interval: CC_INTERVAL_RST,
    rsvd1: 8'h00, cc_count: CC_COUNT_RST, rsvd0: 3'h0, cc_en: 1'b1};
endpackage
`default_nettype wire

// ===== plpc_eq_store.sv
// per-lane transmit equalization store for lanes dropped in reduced width
`default_nettype none
module plpc_eq_store import plpc_pkg::*; #(
  parameter int LANES = 4,
  parameter int EQW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic save,
  input wire logic restore,
  input wire logic [LANES*EQW-1:0] eq_live,
  output logic load_valid,
  output logic [LANES*EQW-1:0] load_data
);
  logic [EQW-1:0] mem_reg [LANES];
  logic [EQW-1:0] mem_next [LANES];
  logic load_valid_next;
  logic [LANES*EQW-1:0] load_data_next;

  always_comb begin
    load_valid_next = restore;
    load_data_next = load_data;
    for (int l = 0; l < LANES; l++) begin
      mem_next[l] = mem_reg[l];
      // only upper lanes are dropped, only they need keeping
      if (save && l >= LANES / 2) begin
        mem_next[l] = eq_live[l*EQW +: EQW];
      end
      if (restore) begin
        load_data_next[l*EQW +: EQW] =
          (l >= LANES / 2) ? mem_reg[l] : eq_live[l*EQW +: EQW];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      load_valid <= 1'b0;
      load_data <= '0;
      for (int l = 0; l < LANES; l++) begin
        mem_reg[l] <= '0;
      end
    end else begin
      load_valid <= load_valid_next;
      load_data <= load_data_next;
      mem_reg <= mem_next;
    end
  end
endmodule
`default_nettype wire

// ===== plpc_ctrl.sv
// low-power state and lane width reduction control with register slave
`default_nettype none
// Notes on behaviour
// - insert clock compensation per programmed count, interval
// - software may disable or retune compensation
// - standby reported as low-power state one
// - sleep reported as low-power state two
// - width reduction is active reduced-power state
// - reduction entry retrains through arc two
// - send 4, receive 2, hold 100 ns
// - no separate retrain sequences during entry
// - keep dropped lanes' equalization on entry
// - reduction exit retrains through arc one
// - send 4, receive 2, wake lanes, 500 ns
// - woken lanes reuse their kept equalization
// - no separate retrain sequences during exit
// - no forwarded clock, timing from lane data
// - lanes run without error correction by default
// - pin loopback needs no control or state
// - status codes 0x7, 0x8, 0xB reported
module plpc_ctrl import plpc_pkg::*; #(
  parameter int LANES = 4,
  parameter int EQW = 8,
  parameter bit STBY_SUP = 1'b1,
  parameter bit SLEEP_SUP = 1'b1,
  parameter bit WR_SUP = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic train_done,
  input wire logic rx_seq_valid,
  input wire plpc_seq_t rx_seq_kind,
  input wire logic [LANES*EQW-1:0] eq_live,
  output logic tx_seq_valid,
  output plpc_seq_t tx_seq_kind,
  output logic [LANES-1:0] lane_en,
  output logic retrain_req,
  output logic [1:0] retrain_arc,
  output logic [3:0] low_power_state_field,
  output logic eq_load_valid,
  output logic [LANES*EQW-1:0] eq_load_data
);
  // bus state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next, status_word, ctrl_word;
  plpc_ctrl_t ctrl_reg, ctrl_next;
  logic [5:0] cmd_go;
  // link state
  plpc_state_t state_reg, state_next;
  logic [2:0] tx_cnt_reg, tx_cnt_next;
  logic [1:0] rx_cnt_reg, rx_cnt_next;
  logic [4:0] hold_cnt_reg, hold_cnt_next;
  logic [15:0] cc_timer_reg, cc_timer_next;
  logic [3:0] cc_burst_reg, cc_burst_next;
  logic [3:0] code_next, prev_reg, prev_next;
  logic tx_valid_next, retrain_next, eq_save, eq_restore;
  plpc_seq_t tx_kind_next;
  logic [1:0] arc_next;
  logic [LANES-1:0] lane_next;
  logic active;

  always_comb begin
    status_word = '0;
    status_word[ST_CODE_LSB +: 4] = low_power_state_field;
    status_word[ST_PREV_LSB +: 4] = prev_reg;
    status_word[ST_LANE_LSB +: LANES] = lane_en;
    status_word[ST_FEC_LSB +: 3] = FEC_NONE;
    awready_next = 1'b0;
    wready_next = 1'b0;
    arready_next = 1'b0;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = s_axi_bvalid && !s_axi_bready;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid && !s_axi_rready;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    ctrl_next = ctrl_reg;
    ctrl_word = ctrl_reg;
    cmd_go = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end else if (s_axi_awvalid && !aw_have_reg && !s_axi_awready) begin
      awready_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end else if (s_axi_wvalid && !w_have_reg && !s_axi_wready) begin
      wready_next = 1'b1;
    end
    if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = AXI_OKAY;
      if (awaddr_reg == ADDR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            ctrl_word[b*8 +: 8] = wdata_reg[b*8 +: 8];
          end
        end
        ctrl_next = ctrl_word;
        ctrl_next.rsvd0 = '0;
        ctrl_next.rsvd1 = '0;
      end else if (awaddr_reg == ADDR_CMD) begin
        cmd_go = wstrb_reg[0] ? wdata_reg[5:0] : 6'h00;
      end else if (awaddr_reg != ADDR_STATUS) begin
        bresp_next = AXI_SLVERR;
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = AXI_OKAY;
      rdata_next = '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rdata_next = status_word;
      end else if (s_axi_araddr != ADDR_CMD) begin
        rresp_next = AXI_SLVERR;
      end
    end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= AXI_OKAY;
      s_axi_rdata <= '0;
      ctrl_reg <= CTRL_RST;
    end else begin
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_arready <= arready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // timing comes from lane data only; loopback needs nothing here
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DOWN: if (train_done) state_next = ST_UP;
      ST_UP: begin
        if (cmd_go[CMD_STBY] && STBY_SUP) state_next = ST_STBY;
        else if (cmd_go[CMD_SLEEP] && SLEEP_SUP) state_next = ST_SLEEP;
        else if (cmd_go[CMD_WR_ENTER] && WR_SUP) state_next = ST_WREQ;
      end
      ST_STBY, ST_SLEEP: if (cmd_go[CMD_WAKE]) state_next = ST_UP;
      ST_WREQ: begin
        if (tx_cnt_reg >= LP_TX_NEED && rx_cnt_reg >= LP_RX_NEED) begin
          state_next = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        if (hold_cnt_reg == 5'(ENTRY_HOLD_CYC - 1)) state_next = ST_WTRAIN;
      end
      ST_WTRAIN: if (train_done) state_next = ST_WRED;
      ST_WRED: if (cmd_go[CMD_WR_EXIT]) state_next = ST_XREQ;
      ST_XREQ: begin
        if (tx_cnt_reg >= LP_TX_NEED && rx_cnt_reg >= LP_RX_NEED) begin
          state_next = ST_XHOLD;
        end
      end
      ST_XHOLD: begin
        if (hold_cnt_reg == 5'(EXIT_HOLD_CYC - 1)) state_next = ST_XTRAIN;
      end
      ST_XTRAIN: if (train_done) state_next = ST_UP;
      default: state_next = ST_DOWN;
    endcase
    if (cmd_go[CMD_DOWN]) state_next = ST_DOWN;
    tx_cnt_next = tx_cnt_reg;
    rx_cnt_next = rx_cnt_reg;
    hold_cnt_next = hold_cnt_reg;
    if (state_next != state_reg) begin
      tx_cnt_next = '0;
      rx_cnt_next = '0;
      hold_cnt_next = '0;
    end else begin
      if (tx_seq_valid && tx_cnt_reg < LP_TX_NEED &&
          (state_reg == ST_WREQ || state_reg == ST_XREQ)) begin
        tx_cnt_next = tx_cnt_reg + 3'h1;
      end
      if (rx_seq_valid && rx_cnt_reg < LP_RX_NEED &&
          ((state_reg == ST_WREQ && rx_seq_kind == SEQ_LP_RED) ||
           (state_reg == ST_XREQ && rx_seq_kind == SEQ_LP_FULL))) begin
        rx_cnt_next = rx_cnt_reg + 2'h1;
      end
      if (state_reg == ST_WHOLD || state_reg == ST_XHOLD) begin
        hold_cnt_next = hold_cnt_reg + 5'h01;
      end
    end
    // compensation bursts only while data flows
    active = (state_next == ST_UP || state_next == ST_WRED) &&
      ctrl_reg.cc_en;
    cc_timer_next = '0;
    cc_burst_next = '0;
    if (active && cc_burst_reg != 4'h0) begin
      cc_timer_next = cc_timer_reg;
      cc_burst_next = cc_burst_reg - 4'h1;
    end else if (active && cc_timer_reg >= ctrl_reg.cc_interval) begin
      cc_burst_next = ctrl_reg.cc_count;
    end else if (active) begin
      cc_timer_next = cc_timer_reg + 16'h0001;
    end
    tx_valid_next = 1'b0;
    tx_kind_next = SEQ_DATA;
    lane_next = '1;
    code_next = CODE_RETRAIN;
    case (state_next)
      ST_DOWN: code_next = CODE_DOWN;
      ST_UP: begin
        code_next = CODE_UP;
        tx_valid_next = active && cc_burst_reg != 4'h0;
        tx_kind_next = tx_valid_next ? SEQ_CC : SEQ_DATA;
      end
      ST_STBY: begin
        code_next = CODE_STBY;
        lane_next = '0;
      end
      ST_SLEEP: begin
        code_next = CODE_SLEEP;
        lane_next = '0;
      end
      ST_WREQ, ST_WHOLD: begin
        tx_valid_next = 1'b1;
        tx_kind_next = SEQ_LP_RED;
      end
      ST_WTRAIN: lane_next = LANES'((1 << (LANES / 2)) - 1);
      ST_WRED: begin
        code_next = CODE_UP_LP1;
        lane_next = LANES'((1 << (LANES / 2)) - 1);
        tx_valid_next = active && cc_burst_reg != 4'h0;
        tx_kind_next = tx_valid_next ? SEQ_CC : SEQ_DATA;
      end
      ST_XREQ: begin
        code_next = CODE_UP_LP1;
        lane_next = LANES'((1 << (LANES / 2)) - 1);
        tx_valid_next = 1'b1;
        tx_kind_next = SEQ_LP_FULL;
      end
      ST_XHOLD: begin
        code_next = CODE_UP_LP1;
        tx_valid_next = 1'b1;
        tx_kind_next = SEQ_LP_FULL;
      end
      default: code_next = CODE_RETRAIN;
    endcase
    retrain_next = 1'b0;
    arc_next = retrain_arc;
    if (state_reg == ST_WHOLD && state_next == ST_WTRAIN) begin
      retrain_next = 1'b1;
      arc_next = ARC_TWO;
    end else if (state_reg == ST_XHOLD && state_next == ST_XTRAIN) begin
      retrain_next = 1'b1;
      arc_next = ARC_ONE;
    end
    eq_save = state_reg == ST_WHOLD && state_next == ST_WTRAIN;
    eq_restore = state_reg == ST_XREQ && state_next == ST_XHOLD;
    prev_next = prev_reg;
    if (code_next != low_power_state_field) prev_next = low_power_state_field;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_DOWN;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      hold_cnt_reg <= '0;
      cc_timer_reg <= '0;
      cc_burst_reg <= '0;
      tx_seq_valid <= 1'b0;
      tx_seq_kind <= SEQ_DATA;
      lane_en <= '1;
      retrain_req <= 1'b0;
      retrain_arc <= ARC_ONE;
      low_power_state_field <= CODE_DOWN;
      prev_reg <= CODE_DOWN;
    end else begin
      state_reg <= state_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      cc_timer_reg <= cc_timer_next;
      cc_burst_reg <= cc_burst_next;
      tx_seq_valid <= tx_valid_next;
      tx_seq_kind <= tx_kind_next;
      lane_en <= lane_next;
      retrain_req <= retrain_next;
      retrain_arc <= arc_next;
      low_power_state_field <= code_next;
      prev_reg <= prev_next;
    end
  end

  plpc_eq_store #(.LANES(LANES), .EQW(EQW)) u_eq (
    .clk(clk),
    .srst(srst),
    .save(eq_save),
    .restore(eq_restore),
    .eq_live(eq_live),
    .load_valid(eq_load_valid),
    .load_data(eq_load_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_entry_gate: assert property ($rose(state_reg == ST_WHOLD) |->
    $past(tx_cnt_reg) >= LP_TX_NEED && $past(rx_cnt_reg) >= LP_RX_NEED)
    else $error("reduction hold entered before handshake complete");
  a_entry_hold: assert property ($rose(state_reg == ST_WHOLD) |->
    (state_reg == ST_WHOLD && tx_seq_kind == SEQ_LP_RED && lane_en == '1)[*5]
    ##1 state_reg == ST_WTRAIN)
    else $error("entry hold not five cycles on all lanes");
  a_exit_hold: assert property ((state_reg == ST_XHOLD &&
    state_next != ST_XHOLD && !cmd_go[CMD_DOWN]) |->
    hold_cnt_reg == 5'(EXIT_HOLD_CYC - 1) && lane_en == '1)
    else $error("exit hold length wrong");
  a_no_retrain_seq: assert property ((state_reg == ST_WREQ ||
    state_reg == ST_XREQ) |-> tx_seq_valid && tx_seq_kind != SEQ_CC &&
    tx_seq_kind != SEQ_DATA)
    else $error("handshake sent other sequences");
  a_entry_arc: assert property ($rose(state_reg == ST_WTRAIN) |->
    retrain_req && retrain_arc == ARC_TWO)
    else $error("entry retrain arc wrong");
  a_exit_arc: assert property ($rose(state_reg == ST_XTRAIN) |->
    retrain_req && retrain_arc == ARC_ONE)
    else $error("exit retrain arc wrong");
  a_eq_restore: assert property ($rose(state_reg == ST_XHOLD) |->
    eq_load_valid)
    else $error("equalization not restored on exit");
  a_reduced_code: assert property (state_reg == ST_WRED |->
    low_power_state_field == CODE_UP_LP1 && lane_en != '1)
    else $error("reduced state code or lanes wrong");
  a_counter_clear: assert property ((state_reg != $past(state_reg)) |->
    tx_cnt_reg == 3'h0 && rx_cnt_reg == 2'h0)
    else $error("handshake counters not cleared");
  a_cc_disable: assert property (!ctrl_reg.cc_en |=>
    !(tx_seq_valid && tx_seq_kind == SEQ_CC))
    else $error("compensation sent while disabled");
endmodule
`default_nettype wire

// ===== plpc_far_end.sv
// remote physical layer and training logic model for the bench
`default_nettype none
module plpc_far_end import plpc_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] delay,
  input wire logic power_up,
  input wire logic tx_seq_valid,
  input wire plpc_seq_t tx_seq_kind,
  input wire logic retrain_req,
  output logic rx_seq_valid,
  output plpc_seq_t rx_seq_kind,
  output logic train_done
);
  timeunit 1ns;
  timeprecision 1ps;
  plpc_seq_t want = SEQ_DATA;
  int wait_cnt = 0;
  int send_left = 0;
  int train_cnt = 0;
  logic is_lp;
  initial begin
    rx_seq_valid = 1'b0;
    rx_seq_kind = SEQ_DATA;
    train_done = 1'b0;
  end
  assign is_lp = tx_seq_valid && tx_seq_kind inside {SEQ_LP_RED, SEQ_LP_FULL};
  always @(posedge clk) begin
    rx_seq_valid <= 1'b0;
    // idle kind toggles so a stale value is never mistaken for a request
    rx_seq_kind <= plpc_seq_t'(~rx_seq_kind);
    train_done <= 1'b0;
    if (srst) begin
      want <= SEQ_DATA;
      wait_cnt <= 0;
      send_left <= 0;
      train_cnt <= 0;
    end else begin
      // answer each new request kind once, after the set delay
      if (is_lp && tx_seq_kind != want) begin
        want <= tx_seq_kind;
        wait_cnt <= int'(delay) + 1;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
      if (wait_cnt == 1) send_left <= 4;
      if (send_left > 0) begin
        rx_seq_valid <= 1'b1;
        rx_seq_kind <= want;
        send_left <= send_left - 1;
      end
      if (retrain_req || power_up) train_cnt <= int'(delay) + 3;
      else if (train_cnt > 0) train_cnt <= train_cnt - 1;
      if (train_cnt == 1) train_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// bench for the low-power width-reduction control
`default_nettype none
module tb import plpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready, power_up;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, train_done;
  logic tx_valid, retrain_req, eq_load_valid;
  logic [1:0] bresp, rresp, retrain_arc;
  logic [7:0] awaddr, araddr, delay;
  logic [3:0] wstrb, lane_en, code;
  logic [31:0] wdata, rdata, eq_live, eq_load_data, eq_seen, eq_pat;
  plpc_seq_t tx_kind, rx_kind, mon_kind;
  int num_errors = 0;
  int num_checks = 0;
  int sent, got, hold, bad_kind, cc_run, cc_len, cc_tot, cc_gap, cc_idle;
  logic met, mon_on;
  logic [1:0] arc_seen;

  plpc_ctrl dut_u (.clk(clk), .srst(srst), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .train_done(train_done), .rx_seq_valid(rx_valid),
    .rx_seq_kind(rx_kind), .eq_live(eq_live), .tx_seq_valid(tx_valid),
    .tx_seq_kind(tx_kind), .lane_en(lane_en), .retrain_req(retrain_req),
    .retrain_arc(retrain_arc), .low_power_state_field(code),
    .eq_load_valid(eq_load_valid), .eq_load_data(eq_load_data));

  plpc_far_end far_u (.clk(clk), .srst(srst), .delay(delay),
    .power_up(power_up), .tx_seq_valid(tx_valid), .tx_seq_kind(tx_kind),
    .retrain_req(retrain_req), .rx_seq_valid(rx_valid),
    .rx_seq_kind(rx_kind), .train_done(train_done));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // handshake and compensation monitor, sampled at each rising edge
  always @(posedge clk) begin
    if (tx_valid && tx_kind == SEQ_CC) begin
      if (cc_run == 0) cc_gap = cc_idle;
      cc_run++;
      cc_tot++;
      cc_idle = 0;
    end else begin
      cc_idle++;
      if (cc_run != 0) begin
        cc_len = cc_run;
        cc_run = 0;
      end
    end
    if (eq_load_valid) eq_seen = eq_load_data;
    if (mon_on) begin
      if (tx_valid && tx_kind != mon_kind) bad_kind++;
      if (tx_valid && tx_kind == mon_kind) sent++;
      if (rx_valid && rx_kind == mon_kind) got++;
      if (met && tx_valid && tx_kind == mon_kind && lane_en == 4'hF) hold++;
      if (sent >= 4 && got >= 2) met = 1'b1;
      if (retrain_req) begin
        mon_on = 1'b0;
        arc_seen = retrain_arc;
      end
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er);
    bit aw_ok, w_ok;
    @(posedge clk);
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
  endtask

  task automatic cmd(input int b);
    wr(ADDR_CMD, 32'h1 << b, AXI_OKAY);
  endtask

  task automatic wait_code(input logic [3:0] c);
    for (int i = 0; i < 2000 && code !== c; i++) @(posedge clk);
    check(code, c);
  endtask

  task automatic arm(input plpc_seq_t k);
    @(negedge clk);
    mon_kind = k;
    sent = 0;
    got = 0;
    hold = 0;
    bad_kind = 0;
    met = 1'b0;
    mon_on = 1'b1;
  endtask

  task automatic wait_retrain;
    for (int i = 0; i < 2000 && mon_on; i++) @(posedge clk);
    check(mon_on, 1'b0);
  endtask

  initial begin
    #(40000 * 20);
    num_errors++;
    report_and_stop;
  end

  initial begin
    {srst, power_up} = 2'b10;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {wstrb, delay, eq_live} = {4'hF, 8'h00, 32'hA1B2C3D4};
    {cc_run, cc_len, cc_tot, mon_on} = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RST, AXI_OKAY);
    rd(ADDR_STATUS, 32'h0000_0F00, AXI_OKAY);
    rd(8'h0C, 32'h0, AXI_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, AXI_SLVERR);
    wr(ADDR_STATUS, 32'hFFFF_FFFF, AXI_OKAY);
    rd(ADDR_STATUS, 32'h0000_0F00, AXI_OKAY);
    rd(ADDR_CMD, 32'h0, AXI_OKAY);
    @(posedge clk);
    power_up <= 1'b1;
    @(posedge clk);
    power_up <= 1'b0;
    wait_code(CODE_UP);
    wr(ADDR_CTRL, 32'h0010_0031, AXI_OKAY);
    rd(ADDR_CTRL, 32'h0010_0031, AXI_OKAY);
    repeat (100) @(posedge clk);
    check(cc_len, 3);
    check(cc_gap, 32'h10 + 1);
    wr(ADDR_CTRL, 32'h0010_0030, AXI_OKAY);
    @(negedge clk);
    cc_tot = 0;
    repeat (60) @(posedge clk);
    check(cc_tot, 0);
    for (int s = 0; s < 2; s++) begin
      cmd(s == 0 ? CMD_STBY : CMD_SLEEP);
      wait_code(s == 0 ? CODE_STBY : CODE_SLEEP);
      check(lane_en, 4'h0);
      cmd(CMD_WAKE);
      wait_code(CODE_UP);
      rd(ADDR_STATUS, s == 0 ? 32'h0000_0F71 : 32'h0000_0F81,
        AXI_OKAY);
    end
    for (int r = 0; r < 2; r++) begin
      eq_pat = 32'hA1B2C3D4 + 32'(r) * 32'h1111_1111;
      delay <= 8'(r * 9);
      eq_live <= eq_pat;
      arm(SEQ_LP_RED);
      cmd(CMD_WR_ENTER);
      wait_retrain;
      check(arc_seen, ARC_TWO);
      check(32'(hold >= ENTRY_HOLD_CYC), 1);
      check(bad_kind, 0);
      wait_code(CODE_UP_LP1);
      check(lane_en, 4'h3);
      eq_live <= ~eq_pat;
      arm(SEQ_LP_FULL);
      cmd(CMD_WR_EXIT);
      wait_retrain;
      check(arc_seen, ARC_ONE);
      check(32'(hold >= EXIT_HOLD_CYC), 1);
      check(bad_kind, 0);
      check(eq_seen[31:16], eq_pat[31:16]);
      wait_code(CODE_UP);
      check(lane_en, 4'hF);
    end
    cmd(CMD_DOWN);
    wait_code(CODE_DOWN);
    report_and_stop;
  end
endmodule
`default_nettype wire
